/* hw/hdf_defs.svh */
// offsets, field positions, reset values and timing figures of the fifo port
`ifndef HDF_DEFS_SVH
`define HDF_DEFS_SVH
`define HDF_RX_WORD_OFS 8'h82
`define HDF_RX_WORD_HI 8'h83
`define HDF_TX_WORD_OFS 8'h84
`define HDF_TX_WORD_HI 8'h85
`define HDF_OPEN_BIT 8
`define HDF_CLOSE_BIT 9
`define HDF_MEND_BIT 8
`define HDF_FIFO_DEPTH 9'h100
`define HDF_RX_MARK_BASE 9'h010
`define HDF_RX_MARK_STEP 9'h020
`define HDF_FLAG_BYTE 8'h7E
`define HDF_ABORT_BYTE 8'hFE
`define HDF_IDLE_BYTE 8'hFF
`define HDF_CRC_INIT 16'hFFFF
`define HDF_CRC_POLY 16'h8408
`define HDF_STUFF_RUN 3'h5
`define HDF_MIN_START 10'h002
`define HDF_SHORT_LIMIT 3'h3
`endif

/* hw/hdf_pkg.sv */
// types shared by the fifo port modules
package hdf_pkg;
  typedef enum logic [2:0] {
    HDF_TX_FILL = 3'b000,
    HDF_TX_OPEN = 3'b001,
    HDF_TX_DATA = 3'b010,
    HDF_TX_CRC = 3'b011,
    HDF_TX_CLOSE = 3'b100,
    HDF_TX_ABORT = 3'b101
  } hdf_tx_state_t;
  typedef enum logic [1:0] {
    HDF_PS_GOOD = 2'b00,
    HDF_PS_BAD_CRC = 2'b01,
    HDF_PS_SHORT = 2'b10,
    HDF_PS_ABORT = 2'b11
  } hdf_pkt_status_t;
endpackage

/* hw/hdf_byte_if.sv */
// byte stream with message-end tag between fifo, buffer and serialiser
`timescale 1ns/100ps
`default_nettype none
interface hdf_byte_if;
  logic valid;
  logic ready;
  logic [8:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* hw/hdf_skid.sv */
// two-entry buffer between transmit fifo and serialiser
`timescale 1ns/100ps
`default_nettype none
module hdf_skid
  import hdf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // streams
  hdf_byte_if.snk up,
  hdf_byte_if.src dn,
  // occupancy
  output logic [1:0] fill
);
  logic [1:0] cnt_ff;
  logic [8:0] slot0_ff;
  logic [8:0] slot1_ff;
  logic push;
  logic pop;

  assign up.ready = (cnt_ff != 2'h2);
  assign dn.valid = (cnt_ff != 2'h0);
  assign dn.data = slot0_ff;
  assign fill = cnt_ff;
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= 2'h0;
    else
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slot0_ff <= 9'h000;
      slot1_ff <= 9'h000;
    end
    else if (pop && cnt_ff == 2'h2)
      slot0_ff <= slot1_ff;
    else if (push && (cnt_ff == 2'h0 || pop))
      slot0_ff <= up.data;
    else if (push)
      slot1_ff <= up.data;
  end
endmodule
`default_nettype wire

/* hw/hdf_port.sv */
// host fifo port of the link controller: rx tagging fifo, tx fifo and serialiser
//
// Functional notes
// R1: high mark flag when count exceeds selected threshold
// R2: received byte in low eight bits
// R3: byte mode: host reads low byte first
// R4: opening tag at bit 8 on first byte
// R5: closing tag at bit 9 on last byte
// R6: status bits 10-11 meaningful with closing tag
// R7: three or fewer bytes report short status
// R8: host ignores data of short packets
// R9: transmit word is write-only, reads zero
// R10: byte mode: host writes low byte first
// R11: transmit fifo holds 256, drops extra writes
// R12: serialise each byte lsb first
// R13: message end appends crc and two flags
// R14: host tags only last byte, packets two+
// R15: start packet only with two bytes queued
// R16: sixteen-bit crc then closing flag 7E
// R17: empty before end: abort FE, fill, underrun
// R18: completed read pops one rx entry
// R19: completed write pushes one tx byte
`timescale 1ns/100ps
`default_nettype none
`include "hdf_defs.svh"
module hdf_port
  import hdf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host register port
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  input wire logic byte_wide_bus_select,
  // control and status
  input wire logic [2:0] rx_high_mark_sel,
  input wire logic tx_fill_idle,
  output logic rx_high_mark_flag,
  output logic rx_fifo_empty,
  output logic rx_overrun,
  output logic tx_fifo_empty,
  output logic tx_fifo_full,
  output logic tx_packet_end,
  output logic tx_underrun,
  // receive deframer side
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic [1:0] rx_end_status,
  // serial transmit side
  input wire logic tx_bit_tick,
  output logic tx_bit
);
  // receive fifo
  logic [11:0] rx_mem [0:255];
  logic [7:0] rx_wp_ff;
  logic [7:0] rx_rp_ff;
  logic [8:0] rx_cnt_ff;
  logic rx_push;
  logic rx_pop;
  logic [11:0] rx_wdata;
  logic [11:0] rx_head;
  logic [8:0] rx_mark_thr;
  // receive tagger
  logic pend_v_ff;
  logic [7:0] pend_d_ff;
  logic pend_open_ff;
  logic first_ff;
  logic [2:0] nbytes_ff;
  logic [1:0] end_status;
  // transmit fifo
  logic [8:0] tx_mem [0:255];
  logic [7:0] tx_wp_ff;
  logic [7:0] tx_rp_ff;
  logic [8:0] tx_cnt_ff;
  logic [7:0] tx_low_ff;
  logic tx_push;
  logic tx_pop;
  logic [8:0] tx_wdata;
  logic [1:0] buf_fill;
  logic [9:0] tx_avail;
  // serialiser
  hdf_tx_state_t state_ff;
  logic [7:0] sh_ff;
  logic [2:0] bcnt_ff;
  logic [2:0] ones_ff;
  logic [15:0] crc_ff;
  logic [15:0] crc_upd;
  logic last_ff;
  logic crc_hi_ff;
  logic bit_ff;
  logic stuff;
  logic boundary;
  logic [7:0] fill_byte;

  hdf_byte_if fifo_s ();
  hdf_byte_if ser_s ();

  hdf_skid u_skid (
    .clk(clk),
    .nrst(nrst),
    .up(fifo_s.snk),
    .dn(ser_s.src),
    .fill(buf_fill)
  );

  // receive tagging ahead of the fifo
  assign end_status = (nbytes_ff <= `HDF_SHORT_LIMIT) ? HDF_PS_SHORT : rx_end_status; // see R7
  always_comb
  begin
    rx_push = 1'b0;
    rx_wdata = {2'b00, 1'b0, pend_open_ff, pend_d_ff}; // see R2 R4
    if (rx_end && pend_v_ff)
    begin
      rx_push = 1'b1;
      rx_wdata = {end_status, 1'b1, pend_open_ff, pend_d_ff}; // see R5 R6
    end
    else if (rx_byte_valid && pend_v_ff)
      rx_push = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_v_ff <= 1'b0;
      pend_d_ff <= 8'h00;
      pend_open_ff <= 1'b0;
      first_ff <= 1'b1;
      nbytes_ff <= 3'h0;
    end
    else if (rx_end)
    begin
      pend_v_ff <= 1'b0;
      first_ff <= 1'b1;
      nbytes_ff <= 3'h0;
    end
    else if (rx_byte_valid)
    begin
      pend_v_ff <= 1'b1;
      pend_d_ff <= rx_byte;
      pend_open_ff <= first_ff; // see R4 R7
      first_ff <= 1'b0;
      if (nbytes_ff != 3'h4)
        nbytes_ff <= nbytes_ff + 3'h1;
    end
  end

  // receive fifo storage
  assign rx_head = rx_mem[rx_rp_ff];
  assign rx_fifo_empty = (rx_cnt_ff == 9'h000);
  assign rx_pop = host_rd && !rx_fifo_empty && ((!byte_wide_bus_select
    && host_addr == `HDF_RX_WORD_OFS) || (byte_wide_bus_select
    && host_addr == `HDF_RX_WORD_HI)); // see R18 R3
  assign rx_mark_thr = `HDF_RX_MARK_BASE + 9'(rx_high_mark_sel) * `HDF_RX_MARK_STEP;
  assign rx_high_mark_flag = (rx_cnt_ff > rx_mark_thr); // see R1

  always_ff @(posedge clk)
  begin
    if (rx_push && (rx_cnt_ff != `HDF_FIFO_DEPTH || rx_pop))
      rx_mem[rx_wp_ff] <= rx_wdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_wp_ff <= 8'h00;
      rx_rp_ff <= 8'h00;
      rx_cnt_ff <= 9'h000;
      rx_overrun <= 1'b0;
    end
    else
    begin
      rx_overrun <= rx_push && rx_cnt_ff == `HDF_FIFO_DEPTH && !rx_pop;
      if (rx_push && (rx_cnt_ff != `HDF_FIFO_DEPTH || rx_pop))
        rx_wp_ff <= rx_wp_ff + 8'h01;
      if (rx_pop)
        rx_rp_ff <= rx_rp_ff + 8'h01;
      if (rx_push && (rx_cnt_ff != `HDF_FIFO_DEPTH || rx_pop) && !rx_pop)
        rx_cnt_ff <= rx_cnt_ff + 9'h001;
      else if (rx_pop && !rx_push)
        rx_cnt_ff <= rx_cnt_ff - 9'h001;
    end
  end

  // host read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      host_rdata <= 16'h0000;
    else if (host_rd)
    begin
      if (host_addr == `HDF_RX_WORD_OFS && !byte_wide_bus_select)
        host_rdata <= {4'h0, rx_head}; // see R2
      else if (host_addr == `HDF_RX_WORD_OFS)
        host_rdata <= {8'h00, rx_head[7:0]}; // see R3
      else if (host_addr == `HDF_RX_WORD_HI && byte_wide_bus_select)
        host_rdata <= {12'h000, rx_head[11:8]};
      else
        host_rdata <= 16'h0000; // see R9
      if (rx_fifo_empty)
        host_rdata <= 16'h0000;
    end
  end

  // transmit fifo fill from host
  assign tx_fifo_empty = (tx_cnt_ff == 9'h000);
  assign tx_fifo_full = (tx_cnt_ff == `HDF_FIFO_DEPTH);
  assign tx_wdata = byte_wide_bus_select ? {host_wdata[0], tx_low_ff}
    : {host_wdata[`HDF_MEND_BIT], host_wdata[7:0]};
  assign tx_push = host_wr && !tx_fifo_full && ((!byte_wide_bus_select
    && host_addr == `HDF_TX_WORD_OFS) || (byte_wide_bus_select
    && host_addr == `HDF_TX_WORD_HI)); // see R19 R10 R11
  assign fifo_s.valid = !tx_fifo_empty;
  assign fifo_s.data = tx_mem[tx_rp_ff];
  assign tx_pop = fifo_s.valid && fifo_s.ready;

  always_ff @(posedge clk)
  begin
    if (tx_push)
      tx_mem[tx_wp_ff] <= tx_wdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_wp_ff <= 8'h00;
      tx_rp_ff <= 8'h00;
      tx_cnt_ff <= 9'h000;
      tx_low_ff <= 8'h00;
    end
    else
    begin
      if (host_wr && byte_wide_bus_select && host_addr == `HDF_TX_WORD_OFS)
        tx_low_ff <= host_wdata[7:0]; // see R10
      if (tx_push)
        tx_wp_ff <= tx_wp_ff + 8'h01;
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 8'h01;
      if (tx_push && !tx_pop)
        tx_cnt_ff <= tx_cnt_ff + 9'h001;
      else if (tx_pop && !tx_push)
        tx_cnt_ff <= tx_cnt_ff - 9'h001;
    end
  end

  // serialiser
  assign tx_avail = {1'b0, tx_cnt_ff} + {8'h00, buf_fill};
  assign fill_byte = tx_fill_idle ? `HDF_IDLE_BYTE : `HDF_FLAG_BYTE;
  assign stuff = (ones_ff == `HDF_STUFF_RUN);
  assign boundary = tx_bit_tick && !stuff && bcnt_ff == 3'h7;
  assign crc_upd = {1'b0, crc_ff[15:1]} ^ ((crc_ff[0] ^ sh_ff[0]) ? `HDF_CRC_POLY : 16'h0000);
  assign ser_s.ready = boundary && (state_ff == HDF_TX_OPEN
    || (state_ff == HDF_TX_DATA && !last_ff));
  assign tx_bit = bit_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= HDF_TX_ABORT;
      sh_ff <= `HDF_ABORT_BYTE;
      bcnt_ff <= 3'h0;
      ones_ff <= 3'h0;
      crc_ff <= `HDF_CRC_INIT;
      last_ff <= 1'b0;
      crc_hi_ff <= 1'b0;
      bit_ff <= 1'b1;
      tx_packet_end <= 1'b0;
      tx_underrun <= 1'b0;
    end
    else
    begin
      tx_packet_end <= 1'b0;
      tx_underrun <= 1'b0;
      if (tx_bit_tick && stuff)
      begin
        bit_ff <= 1'b0;
        ones_ff <= 3'h0;
      end
      else if (tx_bit_tick)
      begin
        bit_ff <= sh_ff[0]; // see R12
        sh_ff <= {1'b0, sh_ff[7:1]};
        bcnt_ff <= bcnt_ff + 3'h1;
        if ((state_ff == HDF_TX_DATA || state_ff == HDF_TX_CRC) && sh_ff[0])
          ones_ff <= ones_ff + 3'h1;
        else
          ones_ff <= 3'h0;
        if (state_ff == HDF_TX_DATA)
          crc_ff <= crc_upd;
        if (boundary)
        begin
          case (state_ff)
            HDF_TX_FILL:
            begin
              if (tx_avail >= `HDF_MIN_START) // see R15
              begin
                state_ff <= HDF_TX_OPEN;
                sh_ff <= `HDF_FLAG_BYTE;
              end
              else
                sh_ff <= fill_byte;
            end
            HDF_TX_OPEN, HDF_TX_DATA:
            begin
              if (state_ff == HDF_TX_DATA && last_ff)
              begin
                state_ff <= HDF_TX_CRC; // see R13 R16
                sh_ff <= ~crc_upd[7:0];
                crc_hi_ff <= 1'b0;
              end
              else if (ser_s.valid)
              begin
                state_ff <= HDF_TX_DATA;
                sh_ff <= ser_s.data[7:0];
                last_ff <= ser_s.data[`HDF_MEND_BIT];
                tx_packet_end <= ser_s.data[`HDF_MEND_BIT];
                if (state_ff == HDF_TX_OPEN)
                  crc_ff <= `HDF_CRC_INIT;
              end
              else
              begin
                state_ff <= HDF_TX_ABORT; // see R17
                sh_ff <= `HDF_ABORT_BYTE;
                tx_underrun <= 1'b1;
                tx_packet_end <= 1'b1;
              end
            end
            HDF_TX_CRC:
            begin
              if (!crc_hi_ff)
              begin
                sh_ff <= ~crc_ff[15:8]; // see R16
                crc_hi_ff <= 1'b1;
              end
              else
              begin
                state_ff <= HDF_TX_CLOSE;
                sh_ff <= `HDF_FLAG_BYTE; // see R16
              end
            end
            HDF_TX_CLOSE:
            begin
              state_ff <= HDF_TX_FILL;
              sh_ff <= `HDF_FLAG_BYTE; // see R13
              last_ff <= 1'b0;
            end
            default:
            begin
              state_ff <= HDF_TX_FILL;
              sh_ff <= fill_byte; // see R17
              last_ff <= 1'b0;
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/hdf_port_props.sv */
// pin-level assertions of the fifo port
`timescale 1ns/100ps
`default_nettype none
module hdf_port_props
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host port
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_rdata,
  input wire logic byte_wide_bus_select,
  // status
  input wire logic rx_high_mark_flag,
  input wire logic rx_fifo_empty,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_full,
  input wire logic tx_packet_end,
  input wire logic tx_underrun,
  // serial side
  input wire logic tx_bit_tick,
  input wire logic tx_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_tx_read_zero:
  assert property (host_rd && host_addr[7:1] == 7'h42 |=> host_rdata == 16'h0000)
    else $error("tx word read not zero");
  a_empty_read_zero:
  assert property (host_rd && host_addr == 8'h82 && rx_fifo_empty |=> host_rdata == 16'h0000)
    else $error("empty rx read not zero");
  a_rdata_holds:
  assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved without read");
  a_mark_needs_data:
  assert property (rx_high_mark_flag |-> !rx_fifo_empty)
    else $error("high mark with empty fifo");
  a_tx_not_both:
  assert property (!(tx_fifo_empty && tx_fifo_full))
    else $error("tx fifo empty and full");
  a_underrun_ends:
  assert property (tx_underrun |-> tx_packet_end ##1 !tx_underrun)
    else $error("underrun without packet end");
  a_bit_on_tick:
  assert property (!$past(tx_bit_tick) |-> $stable(tx_bit))
    else $error("serial bit moved without tick");
  a_write_fills:
  assert property (host_wr && host_addr == 8'h84 && !byte_wide_bus_select && !tx_fifo_full
    |=> !tx_fifo_empty)
    else $error("tx write not stored");
  c_underrun: cover property (tx_underrun);
  c_packet_end: cover property (tx_packet_end && !tx_underrun);
  c_high_mark: cover property (rx_high_mark_flag);
endmodule
`default_nettype wire

/* test/hdf_host_model.sv */
// host processor model driving the fifo port registers
`timescale 1ns/100ps
`default_nettype none
module hdf_host_model
(
  // clock
  input wire logic clk,
  // register bus
  output logic [7:0] host_addr,
  output logic host_rd,
  output logic host_wr,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata
);
  initial
  begin
    host_addr = 8'h00;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 16'h0000;
  end
  // byte mode callers issue low byte first
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    host_addr <= ~a;
    @(posedge clk);
    d = host_rdata;
  endtask
  // idle gap keeps the strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= v;
    @(posedge clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/hdf_port_bench.sv */
// self-checking bench of the fifo port
`timescale 1ns/100ps
`default_nettype none
module hdf_port_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] host_addr;
  logic host_rd, host_wr;
  logic [15:0] host_wdata, host_rdata, d;
  logic byte_wide_bus_select = 1'b0;
  logic [2:0] rx_high_mark_sel = 3'h0;
  logic tx_fill_idle = 1'b1;
  logic rx_byte_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_end = 1'b0;
  logic [1:0] rx_end_status = 2'h0;
  logic tx_bit_tick = 1'b0;
  logic rx_high_mark_flag, rx_fifo_empty, rx_overrun, tx_fifo_empty, tx_fifo_full;
  logic tx_packet_end, tx_underrun, tx_bit;
  logic [23:0] sh = 24'h00_0000;
  logic [2:0] seen = 3'h0;
  logic udr = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  initial forever #2.5 clk = ~clk;
  hdf_host_model i_hdf_host_model (.clk, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata);
  hdf_port i_hdf_port (.clk, .nrst, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .byte_wide_bus_select, .rx_high_mark_sel, .tx_fill_idle,
    .rx_high_mark_flag, .rx_fifo_empty, .rx_overrun, .tx_fifo_empty, .tx_fifo_full,
    .tx_packet_end, .tx_underrun, .rx_byte_valid, .rx_byte, .rx_end, .rx_end_status,
    .tx_bit_tick, .tx_bit);
  // serial capture: frame, closing flags, end and underrun pulses
  always @(posedge clk)
  begin
    sh <= {sh[22:0], tx_bit};
    if (!nrst)
      {seen, udr} <= 4'h0;
    else
    begin
      if (sh == 24'h7e_a53c) seen[2] <= 1'b1;
      if (sh == 24'h7e_7eff) seen[1] <= 1'b1;
      if (tx_packet_end === 1'b1) seen[0] <= 1'b1;
      if (tx_underrun === 1'b1) udr <= 1'b1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  task automatic rx_put(input logic [7:0] b);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    @(posedge clk);
  endtask
  task automatic rx_fin(input logic [1:0] st);
    rx_end <= 1'b1;
    rx_end_status <= st;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_end_status <= ~st;
    repeat (2) @(posedge clk);
  endtask
  task automatic rx_get(input logic [15:0] m, input logic [15:0] e);
    i_hdf_host_model.rd(8'h82, d);
    chk(d & m, e);
  endtask
  task automatic t_rx_status();
    for (int s = 0; s < 4; s++)
    begin
      for (int k = 0; k < 4; k++) rx_put(8'h81 + 8'(k));
      rx_fin(2'(s));
      rx_get(16'h03ff, 16'h0181);
      rx_get(16'h03ff, 16'h0082);
      rx_get(16'h03ff, 16'h0083);
      rx_get(16'h0fff, {4'h0, 2'(s), 10'h284});
    end
  endtask
  task automatic t_rx_short();
    rx_put(8'h5a);
    rx_fin(2'h0);
    rx_get(16'hffff, 16'h0b5a);
    for (int k = 1; k < 4; k++) rx_put(8'(k));
    rx_fin(2'h0);
    rx_get(16'h0300, 16'h0100);
    rx_get(16'h0300, 16'h0000);
    rx_get(16'h0f00, 16'h0a00);
    rx_get(16'hffff, 16'h0000);
  endtask
  task automatic t_byte_mode();
    byte_wide_bus_select <= 1'b1;
    rx_put(8'hc3);
    rx_put(8'h3c);
    rx_fin(2'h0);
    rx_get(16'hffff, 16'h00c3);
    rx_get(16'hffff, 16'h00c3);
    i_hdf_host_model.rd(8'h83, d);
    chk(d & 16'hfff3, 16'h0001);
    rx_get(16'hffff, 16'h003c);
    i_hdf_host_model.rd(8'h83, d);
    chk(d, 16'h000a);
    chk({15'h0000, rx_fifo_empty}, 16'h0001);
    byte_wide_bus_select <= 1'b0;
  endtask
  task automatic t_mark();
    do_reset();
    for (int n = 1; n < 258; n++)
    begin
      rx_put(8'(n));
      for (int s = 0; s < 8; s++)
      begin
        rx_high_mark_sel <= 3'(s);
        @(posedge clk);
        chk({15'h0000, rx_high_mark_flag}, {15'h0000, (n - 1) > 16 + 32 * s});
      end
    end
    rx_byte_valid <= 1'b1;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    @(negedge clk);
    chk({15'h0000, rx_overrun}, 16'h0001);
    @(posedge clk);
  endtask
  task automatic t_tx_frame();
    do_reset();
    tx_bit_tick <= 1'b1;
    repeat (30) @(posedge clk);
    i_hdf_host_model.wr(8'h84, 16'h00a5);
    repeat (40) @(posedge clk);
    chk(sh[15:0], 16'hffff);
    i_hdf_host_model.wr(8'h84, 16'h013c);
    i_hdf_host_model.rd(8'h84, d);
    chk(d, 16'h0000);
    repeat (100) @(posedge clk);
    chk({13'h0000, seen}, 16'h0007);
  endtask
  task automatic t_tx_bytes();
    do_reset();
    tx_bit_tick <= 1'b1;
    tx_fill_idle <= 1'b1;
    byte_wide_bus_select <= 1'b1;
    i_hdf_host_model.wr(8'h84, 16'h00a5);
    i_hdf_host_model.wr(8'h85, 16'h0000);
    i_hdf_host_model.wr(8'h84, 16'h003c);
    i_hdf_host_model.wr(8'h85, 16'h0001);
    repeat (100) @(posedge clk);
    chk({13'h0000, seen}, 16'h0007);
    byte_wide_bus_select <= 1'b0;
  endtask
  task automatic t_tx_underrun();
    do_reset();
    tx_fill_idle <= 1'b0;
    repeat (20) @(posedge clk);
    i_hdf_host_model.wr(8'h84, 16'h0011);
    i_hdf_host_model.wr(8'h84, 16'h0022);
    repeat (100) @(posedge clk);
    chk({14'h0000, udr, seen[0]}, 16'h0003);
  endtask
  task automatic t_tx_full();
    do_reset();
    tx_bit_tick <= 1'b0;
    for (int k = 0; k < 262; k++)
    begin
      if (k == 254) chk({15'h0000, tx_fifo_full}, 16'h0000);
      i_hdf_host_model.wr(8'h84, 16'(k & 255));
    end
    chk({15'h0000, tx_fifo_full}, 16'h0001);
  endtask
  initial
  begin
    do_reset();
    t_rx_status();
    t_rx_short();
    t_byte_mode();
    t_mark();
    t_tx_frame();
    t_tx_bytes();
    t_tx_underrun();
    t_tx_full();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
bind hdf_port hdf_port_props i_hdf_port_props (.clk, .nrst, .host_addr, .host_rd,
  .host_wr, .host_rdata, .byte_wide_bus_select, .rx_high_mark_flag, .rx_fifo_empty,
  .tx_fifo_empty, .tx_fifo_full, .tx_packet_end, .tx_underrun, .tx_bit_tick, .tx_bit);
`default_nettype wire
